// *** fsc_dev.sv ***
// Scan device end: word decode, sequencer, accumulator and outputs
`timescale 1ns/100ps
`default_nettype none
`include "fsc_defs.svh"
module fsc_dev (
    // Clock and reset
    input  wire logic    REF_CLK_I,
    input  wire logic    RSTN_I,
    // Link from host
    fsc_link_if.dev      LINK,
    // Analog path
    output logic [9:0]   DAC_DATA_O,
    output logic         DAC_ON_O,
    // Digital outputs
    output logic         SQUARE_WAVE_O,
    output logic         SCAN_MARKER_O,
    output logic         SCAN_MARKER_OE_O
);
    ////////////////////////////////////////////////////////////////////////
    // Quarter-wave sine table, 32 entries of amplitude above midscale
    localparam logic [0:31][8:0] SINE_Q = {
        9'h00d, 9'h026, 9'h03f, 9'h057, 9'h070, 9'h088, 9'h0a0, 9'h0b8,
        9'h0cf, 9'h0e6, 9'h0fc, 9'h111, 9'h126, 9'h13a, 9'h14e, 9'h160,
        9'h172, 9'h183, 9'h193, 9'h1a2, 9'h1b0, 9'h1bd, 9'h1c8, 9'h1d3,
        9'h1dd, 9'h1e5, 9'h1ed, 9'h1f3, 9'h1f7, 9'h1fb, 9'h1fe, 9'h1ff
    };

    // Multiplier code to base events per hold tick
    function automatic logic [8:0] mult_of(input logic [1:0] code);
        logic [8:0] m;
        m = `FSC_MULT_1;
        unique case (code)
            2'h0: m = `FSC_MULT_1;
            2'h1: m = `FSC_MULT_5;
            2'h2: m = `FSC_MULT_100;
            2'h3: m = `FSC_MULT_500;
        endcase
        return m;
    endfunction

    // Phase to sine sample
    function automatic logic [9:0] sine_of(input logic [23:0] ph);
        logic [4:0] idx;
        logic [9:0] amp;
        idx = ph[22] ? ~ph[21:17] : ph[21:17];
        amp = {1'b0, SINE_Q[idx]};
        return ph[23] ? 10'(`FSC_MIDSCALE - amp) : 10'(`FSC_MIDSCALE + amp);
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // Pin synchronisers: control, abort, standby
    logic [2:0] pin_raw;
    logic [2:0] pin_lvl;
    logic [2:0] pin_rise;

    assign pin_raw = {LINK.standby, LINK.scan_abort, LINK.scan_ctrl};

    // One synchroniser per pin
    for (genvar g = 0; g < 3; g++) begin : g_sync
        fsc_pin_sync u_sync (
            .REF_CLK_I (REF_CLK_I),
            .RSTN_I    (RSTN_I),
            .PIN_I     (pin_raw[g]),
            .LEVEL_O   (pin_lvl[g]),
            .RISE_O    (pin_rise[g])
        );
    end

    logic ctrl_rise;
    logic abort_rise;
    logic stby;

    assign ctrl_rise  = pin_rise[0];
    assign abort_rise = pin_rise[1];
    assign stby       = pin_lvl[2];

    ////////////////////////////////////////////////////////////////////////
    // State
    fsc_pkg::fsc_dev_s r;
    fsc_pkg::fsc_dev_s next_r;

    // Sequencer, word decode and output shaping
    always_comb begin
        logic [24:0] acc;
        logic        wrap;
        logic        ev;
        logic        tick;
        logic        step;
        logic [15:0] w;
        acc    = {1'b0, r.phase} + {1'b0, r.freq};
        wrap   = acc[24];
        ev     = 1'b0;
        tick   = 1'b0;
        step   = 1'b0;
        w      = LINK.word;
        next_r = r;
        if (!stby) begin
            // Accumulator runs at the current word
            if (r.state != fsc_pkg::FSC_IDLE) begin
                next_r.phase = acc[23:0];
            end
            if (r.mpulse != 3'h0) begin
                next_r.mpulse = 3'(r.mpulse - 3'h1);
            end

            // Base event: a clock period or a completed output cycle
            ev = r.tunit ? 1'b1 : wrap;

            // Sequencer
            unique case (r.state)
                fsc_pkg::FSC_IDLE: begin
                    if (ctrl_rise) begin
                        next_r.state = fsc_pkg::FSC_RUN;
                        next_r.freq  = r.start_f;
                        next_r.phase = '0;
                        next_r.pre   = '0;
                        next_r.hold  = '0;
                        next_r.left  = r.steps;
                        next_r.eos   = 1'b0;
                    end
                end
                fsc_pkg::FSC_RUN: begin
                    if (r.ext) begin
                        step = ctrl_rise;
                    end else if (ev) begin
                        if (r.pre == 9'(mult_of(r.tmul) - 9'h1)) begin
                            next_r.pre = '0;
                            tick       = 1'b1;
                        end else begin
                            next_r.pre = 9'(r.pre + 9'h1);
                        end
                        if (tick) begin
                            if (r.hold == 11'(r.ival - 11'h1)) begin
                                next_r.hold = '0;
                                step        = 1'b1;
                            end else begin
                                next_r.hold = 11'(r.hold + 11'h1);
                            end
                        end
                    end
                    if (step) begin
                        next_r.freq = r.dneg ?
                            24'(r.freq - {1'b0, r.delta}) :
                            24'(r.freq + {1'b0, r.delta});
                        next_r.left   = 12'(r.left - 12'h1);
                        next_r.mpulse = `FSC_MARK_CYC;
                        if (r.left <= 12'h1) begin
                            next_r.state = fsc_pkg::FSC_DONE;
                            next_r.eos   = 1'b1;
                        end
                    end
                end
                fsc_pkg::FSC_DONE: begin
                    next_r.state = fsc_pkg::FSC_DONE;
                end
            endcase

            // Word decode
            if (LINK.word_stb) begin
                if (w[15:14] == `FSC_PFX_INTERVAL) begin
                    next_r.tunit = w[`FSC_IB_UNIT];
                    next_r.tmul  = w[12:11];
                    next_r.ival  = w[10:0];
                end else begin
                    unique case (w[15:12])
                        `FSC_PFX_STEPS: next_r.steps = w[11:0];
                        `FSC_PFX_DLSB:  next_r.delta[11:0] = w[11:0];
                        `FSC_PFX_DMSB: begin
                            next_r.delta[22:12] = w[10:0];
                            next_r.dneg         = w[`FSC_DB_NEG];
                        end
                        `FSC_PFX_FSLSB: next_r.start_f[11:0]  = w[11:0];
                        `FSC_PFX_FSMSB: next_r.start_f[23:12] = w[11:0];
                        `FSC_PFX_CTRL: begin
                            next_r.dac_en  = w[`FSC_CB_DAC_EN];
                            next_r.sine    = w[`FSC_CB_SINE];
                            next_r.sq_en   = w[`FSC_CB_SQ_EN];
                            next_r.ext     = w[`FSC_CB_EXT];
                            next_r.mk_mode = w[`FSC_CB_MK_MODE];
                            next_r.mk_en   = w[`FSC_CB_MK_EN];
                            // A control write also resets the sequencer
                            next_r.state   = fsc_pkg::FSC_IDLE;
                            next_r.phase   = '0;
                            next_r.mpulse  = '0;
                            next_r.eos     = 1'b0;
                        end
                        default: ;
                    endcase
                end
            end

            // Abort wins over everything else except standby
            if (abort_rise) begin
                next_r.state  = fsc_pkg::FSC_IDLE;
                next_r.phase  = '0;
                next_r.pre    = '0;
                next_r.hold   = '0;
                next_r.mpulse = '0;
                next_r.eos    = 1'b0;
            end

            // Output shaping from the current phase
            if (r.state == fsc_pkg::FSC_IDLE) begin
                next_r.dac    = `FSC_MIDSCALE;
                next_r.square = 1'b0;
            end else begin
                next_r.dac = r.sine ? sine_of(r.phase) :
                    (r.phase[23] ? ~r.phase[22:13] : r.phase[22:13]);
                next_r.square = r.sq_en & ~r.phase[23];
            end
        end
    end

    // State register
    always_ff @(posedge REF_CLK_I) begin
        if (!RSTN_I) begin
            r       <= '0;
            r.state <= fsc_pkg::FSC_IDLE;
            r.ival  <= `FSC_RST_IVAL;
            r.steps <= `FSC_RST_STEPS;
            r.dac   <= `FSC_MIDSCALE;
        end else begin
            r <= next_r;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Outputs
    assign DAC_DATA_O       = r.dac;
    assign DAC_ON_O         = r.dac_en;
    assign SQUARE_WAVE_O    = r.square;
    assign SCAN_MARKER_OE_O = r.mk_en;
    assign SCAN_MARKER_O    = r.mk_en &
        (r.mk_mode ? r.eos : (r.mpulse != 3'h0));
endmodule
`default_nettype wire

// *** fsc_defs.svh ***
// Constants of the frequency scan controller: word codes, fields, timing
// Functional notes
// - D13 picks waveform cycles or clock periods
// - Prefix 01 in D15:D14 loads increment interval
// - Hold count is 11 bits, at least 2
// - Hold up to 2047 base intervals each
// - D12:D11 multiplier of 1, 5, 100, 500
// - Multiplier applies to both count units
// - Scan spans step count intervals
// - Rising control pin starts from start frequency
// - Each step adds or subtracts frequency step, step-count times
// - Control D5 low: self-timed stepping
// - Control D5 high: pin edges start and step
// - Abort edge resets sequencer, output midscale
// - Standby freezes accumulator and output
// - Host resets around standby, then restarts
// - D9 selects sine table or triangle
// - D10 enables analog output
// - D8 enables inverted accumulator top bit
// - D2 enables marker, D3 selects its kind
// - Marker end-of-scan level or 4-clock pulse
// - Step count 12 bits, 2 to 4095
`ifndef FSC_DEFS_SVH
`define FSC_DEFS_SVH

// Word prefixes
`define FSC_PFX_INTERVAL 2'h1
`define FSC_PFX_CTRL     4'h0
`define FSC_PFX_STEPS    4'h1
`define FSC_PFX_DLSB     4'h2
`define FSC_PFX_DMSB     4'h3
`define FSC_PFX_FSLSB    4'hc
`define FSC_PFX_FSMSB    4'hd

// Field positions
`define FSC_IB_UNIT      13
`define FSC_DB_NEG       11
`define FSC_CB_DAC_EN    10
`define FSC_CB_SINE      9
`define FSC_CB_SQ_EN     8
`define FSC_CB_EXT       5
`define FSC_CB_MK_MODE   3
`define FSC_CB_MK_EN     2

// Time-base multipliers
`define FSC_MULT_1       9'h001
`define FSC_MULT_5       9'h005
`define FSC_MULT_100     9'h064
`define FSC_MULT_500     9'h1f4

// Output values and timing
`define FSC_MIDSCALE     10'h200
`define FSC_MARK_CYC     3'h4

// Reset values of hold count and step count
`define FSC_RST_IVAL     11'h002
`define FSC_RST_STEPS    12'h002

// Host register offsets and pin bit positions
`define FSC_H_SEND       2'h0
`define FSC_H_PINS       2'h1
`define FSC_PIN_CTRL     0
`define FSC_PIN_ABORT    1
`define FSC_PIN_STBY     2

`endif

// *** fsc_pkg.sv ***
// Types of the frequency scan controller
package fsc_pkg;

    // Scan sequencer states
    typedef enum logic [2:0] {
        FSC_IDLE = 3'b001,
        FSC_RUN  = 3'b010,
        FSC_DONE = 3'b100
    } fsc_state_e;

    // Device state
    typedef struct packed {
        fsc_state_e  state;
        logic [23:0] phase;
        logic [23:0] freq;
        logic [23:0] start_f;
        logic [22:0] delta;
        logic        dneg;
        logic [11:0] steps;
        logic [10:0] ival;
        logic        tunit;
        logic [1:0]  tmul;
        logic        dac_en;
        logic        sine;
        logic        sq_en;
        logic        ext;
        logic        mk_mode;
        logic        mk_en;
        logic [8:0]  pre;
        logic [10:0] hold;
        logic [11:0] left;
        logic [2:0]  mpulse;
        logic        eos;
        logic [9:0]  dac;
        logic        square;
    } fsc_dev_s;

    // Pin synchroniser state
    typedef struct packed {
        logic s1;
        logic s2;
        logic s3;
        logic lvl;
        logic rise;
    } fsc_sync_s;

    // Host state
    typedef struct packed {
        logic [15:0] word;
        logic        stb;
        logic [2:0]  pins;
        logic [15:0] rdata;
    } fsc_host_s;

endpackage

// *** fsc_link_if.sv ***
// Link between host and scan device: word port and control pins
`timescale 1ns/100ps
`default_nettype none
interface fsc_link_if;
    logic [15:0] word;
    logic        word_stb;
    logic        scan_ctrl;
    logic        scan_abort;
    logic        standby;

    modport dev (
        input word,
        input word_stb,
        input scan_ctrl,
        input scan_abort,
        input standby
    );

    modport host (
        output word,
        output word_stb,
        output scan_ctrl,
        output scan_abort,
        output standby
    );
endinterface
`default_nettype wire

// *** fsc_pin_sync.sv ***
// Three-stage pin synchroniser with rising-edge pulse
`timescale 1ns/100ps
`default_nettype none
module fsc_pin_sync (
    // Clock and reset
    input  wire logic REF_CLK_I,
    input  wire logic RSTN_I,
    // Pin and results
    input  wire logic PIN_I,
    output logic      LEVEL_O,
    output logic      RISE_O
);
    fsc_pkg::fsc_sync_s r;
    fsc_pkg::fsc_sync_s next_r;

    // Level accepted once stages two and three agree
    always_comb begin
        next_r      = r;
        next_r.s1   = PIN_I;
        next_r.s2   = r.s1;
        next_r.s3   = r.s2;
        next_r.rise = 1'b0;
        if (r.s2 == r.s3) begin
            next_r.lvl  = r.s3;
            next_r.rise = r.s3 & ~r.lvl;
        end
    end

    // State register
    always_ff @(posedge REF_CLK_I) begin
        if (!RSTN_I) begin
            r <= '0;
        end else begin
            r <= next_r;
        end
    end

    assign LEVEL_O = r.lvl;
    assign RISE_O  = r.rise;
endmodule
`default_nettype wire

// *** fsc_host.sv ***
// Host end: sends words and drives control pins from a register port
`timescale 1ns/100ps
`default_nettype none
`include "fsc_defs.svh"
module fsc_host (
    // Clock and reset
    input  wire logic        REF_CLK_I,
    input  wire logic        RSTN_I,
    // Register port
    input  wire logic [1:0]  ADDR_I,
    input  wire logic [15:0] WDATA_I,
    input  wire logic        WR_I,
    input  wire logic        RD_I,
    output logic [15:0]      RDATA_O,
    // Link to device
    fsc_link_if.host         LINK
);
    fsc_pkg::fsc_host_s r;
    fsc_pkg::fsc_host_s next_r;

    // Word send, pin levels and read-back
    always_comb begin
        next_r       = r;
        next_r.stb   = 1'b0;
        next_r.rdata = '0;
        if (WR_I) begin
            unique case (ADDR_I)
                `FSC_H_SEND: begin
                    next_r.word = WDATA_I;
                    next_r.stb  = 1'b1;
                end
                `FSC_H_PINS: next_r.pins = WDATA_I[2:0];
                default: ;
            endcase
        end
        if (RD_I) begin
            unique case (ADDR_I)
                `FSC_H_SEND: next_r.rdata = r.word;
                `FSC_H_PINS: next_r.rdata = {13'h0000, r.pins};
                default:     next_r.rdata = '0;
            endcase
        end
    end

    // State register
    always_ff @(posedge REF_CLK_I) begin
        if (!RSTN_I) begin
            r <= '0;
        end else begin
            r <= next_r;
        end
    end

    // Link drive
    assign LINK.word       = r.word;
    assign LINK.word_stb   = r.stb;
    assign LINK.scan_ctrl  = r.pins[`FSC_PIN_CTRL];
    assign LINK.scan_abort = r.pins[`FSC_PIN_ABORT];
    assign LINK.standby    = r.pins[`FSC_PIN_STBY];
    assign RDATA_O         = r.rdata;
endmodule
`default_nettype wire

// *** fsc_chk.sv ***
// Assertions on the host-device link and the device outputs
`timescale 1ns/100ps
`default_nettype none
module fsc_chk (
    // Clock and reset
    input wire logic        REF_CLK_I,
    input wire logic        RSTN_I,
    // Link signals and host port
    input wire logic [15:0] word,
    input wire logic        word_stb,
    input wire logic        scan_ctrl,
    input wire logic        scan_abort,
    input wire logic        standby,
    input wire logic [1:0]  ADDR_I,
    input wire logic        WR_I,
    // Device outputs
    input wire logic [9:0]  DAC_DATA_O,
    input wire logic        DAC_ON_O,
    input wire logic        SQUARE_WAVE_O,
    input wire logic        SCAN_MARKER_O,
    input wire logic        SCAN_MARKER_OE_O
);
    logic        ctl_wr;
    logic [15:0] ctl_q;

    default clocking cb @(posedge REF_CLK_I);
    endclocking
    default disable iff (!RSTN_I);

    // Copy of the last control word taken by the device
    assign ctl_wr = word_stb && !standby && (word[15:12] == 4'h0);
    always_ff @(posedge REF_CLK_I) begin
        if (!RSTN_I) begin
            ctl_q <= 16'h0000;
        end else if (ctl_wr) begin
            ctl_q <= word;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    a_ctl_to_outs: assert property (ctl_wr |=>
        DAC_ON_O == ctl_q[10] && SCAN_MARKER_OE_O == ctl_q[2])
        else $error("enables differ from control word");
    a_dac_on_cause: assert property (
        $changed(DAC_ON_O) && $past(RSTN_I) |-> $past(ctl_wr))
        else $error("analog enable moved without control write");
    a_word_cause: assert property (
        $changed(word) && $past(RSTN_I) |-> word_stb)
        else $error("word changed without strobe");
    a_stb_cause: assert property (
        word_stb |-> $past(WR_I) && $past(ADDR_I) == 2'h0)
        else $error("strobe without send write");
    a_pins_cause: assert property (
        $changed({scan_ctrl, scan_abort, standby}) && $past(RSTN_I)
        |-> $past(WR_I) && $past(ADDR_I) == 2'h1)
        else $error("pin moved without pin write");
    a_abort_mid: assert property (
        $rose(scan_abort) && !standby
        |-> ##[3:8] (DAC_DATA_O == 10'h200 && !SQUARE_WAVE_O))
        else $error("abort did not reach midscale");
    a_marker_pulse: assert property (
        $rose(SCAN_MARKER_O) && !ctl_q[3] && !scan_abort
        |-> SCAN_MARKER_O[*4] ##1 !SCAN_MARKER_O)
        else $error("marker pulse not four cycles");
    a_marker_off: assert property (
        !ctl_q[2] |-> !SCAN_MARKER_OE_O && !SCAN_MARKER_O)
        else $error("marker high while not driven");

    // Main scenarios
    c_abort: cover property ($rose(scan_abort));
    c_eos: cover property ($rose(SCAN_MARKER_O) && ctl_q[3]);
    c_step: cover property ($rose(SCAN_MARKER_O) && !ctl_q[3]);
    c_ext: cover property (ctl_wr && word[5]);
endmodule
`default_nettype wire

// *** frequency_scan_controller_tb.sv ***
// Testbench joining host and device ends of the scan controller
`timescale 1ns/100ps
`default_nettype none
module frequency_scan_controller_tb;
    logic        clk = 1'b0;
    logic        rstn = 1'b0;
    logic [1:0]  addr = 2'h0;
    logic [15:0] wdata = 16'h0;
    logic        wr = 1'b0;
    logic        rd = 1'b0;
    logic [15:0] rdata;
    logic [9:0]  dac;
    logic        dac_on;
    logic        sq;
    logic        mk;
    logic        mk_oe;
    logic        mk_prev = 1'b0;
    int          bad_count = 0;
    int          tests_run = 0;
    int          cyc = 0;
    int          mk_cnt = 0;
    int          mk_gap = 0;
    int          mk_last = 0;
    int          base, n, k, g, t0;
    int          tt[2];
    int          mulv[4] = '{1, 5, 100, 500};
    logic [1:0]  m;
    logic        u;
    logic [15:0] rv;
    logic [9:0]  d0;

    fsc_link_if link ();

    fsc_host fsc_host_i (.REF_CLK_I(clk), .RSTN_I(rstn), .ADDR_I(addr),
        .WDATA_I(wdata), .WR_I(wr), .RD_I(rd), .RDATA_O(rdata), .LINK(link));
    fsc_dev fsc_dev_i (.REF_CLK_I(clk), .RSTN_I(rstn), .LINK(link),
        .DAC_DATA_O(dac), .DAC_ON_O(dac_on), .SQUARE_WAVE_O(sq),
        .SCAN_MARKER_O(mk), .SCAN_MARKER_OE_O(mk_oe));
    fsc_chk fsc_chk_i (.REF_CLK_I(clk), .RSTN_I(rstn), .word(link.word),
        .word_stb(link.word_stb), .scan_ctrl(link.scan_ctrl),
        .scan_abort(link.scan_abort), .standby(link.standby),
        .ADDR_I(addr), .WR_I(wr), .DAC_DATA_O(dac), .DAC_ON_O(dac_on),
        .SQUARE_WAVE_O(sq), .SCAN_MARKER_O(mk), .SCAN_MARKER_OE_O(mk_oe));

    // Clock, 20 ns period
    always #10 clk = ~clk;

    // Marker rise counter and spacing
    always @(posedge clk) begin
        cyc = cyc + 1;
        if (mk && !mk_prev) begin
            mk_cnt = mk_cnt + 1;
            mk_gap = cyc - mk_last;
            mk_last = cyc;
        end
        mk_prev = mk;
    end

    ////////////////////////////////////////////////////////////////////////
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            bad_count++;
            $display("unexpected at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask

    // Expected clocks between markers; 4 clocks per cycle at 24'h400000
    function automatic int hold_gap(input int cnt, input logic [1:0] code,
                                    input logic unit);
        return cnt * mulv[code] * (unit ? 1 : 4);
    endfunction

    task automatic complete_run;
        $display("comparisons %0d mismatches %0d", tests_run, bad_count);
        if (bad_count == 0 && tests_run > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    // Register port cycles
    task automatic wr_reg(input logic [1:0] a, input logic [15:0] d);
        @(posedge clk);
        wr <= 1'b1;
        addr <= a;
        wdata <= d;
        @(posedge clk);
        wr <= 1'b0;
    endtask

    task automatic rd_reg(input logic [1:0] a, output logic [15:0] d);
        @(posedge clk);
        rd <= 1'b1;
        addr <= a;
        @(posedge clk);
        rd <= 1'b0;
        #1 d = rdata;
    endtask

    task automatic pins(input logic [2:0] v);
        wr_reg(2'h1, {13'h0, v});
        repeat (6) @(posedge clk);
    endtask

    task automatic pulse_ctrl;
        pins(3'h1);
        pins(3'h0);
    endtask

    // Interval, count, start, step and control words; control goes last
    task automatic prog(input logic [13:0] iv, input logic [11:0] kk,
                        input logic [23:0] f, input logic [23:0] d,
                        input logic [2:0] c);
        wr_reg(2'h0, {2'b01, iv});
        wr_reg(2'h0, {4'h1, kk});
        wr_reg(2'h0, {4'hc, f[11:0]});
        wr_reg(2'h0, {4'hd, f[23:12]});
        wr_reg(2'h0, {4'h2, d[11:0]});
        wr_reg(2'h0, {4'h3, d[23], d[22:12]});
        wr_reg(2'h0, {6'h01, c[0], 1'b1, 2'h0, c[2], 1'b0, c[1], 3'h7});
        repeat (3) @(posedge clk);
    endtask

    task automatic wait_mk(input int target, input int bound);
        int i;
        i = 0;
        while (mk_cnt < target && i < bound) begin
            @(posedge clk);
            i++;
        end
        chk(mk_cnt >= target, 1);
    endtask

    task automatic sq_period(input int exp);
        int s;
        @(posedge sq);
        s = cyc;
        @(posedge sq);
        chk(cyc - s, exp);
    endtask

    // Sum of one output period of len samples
    task automatic wave_sum(input int len, input int exp);
        int s;
        s = 0;
        repeat (len) begin
            @(posedge clk);
            s += dac;
        end
        chk(s, exp);
    endtask

    ////////////////////////////////////////////////////////////////////////
    // Watchdog
    initial begin
        repeat (60000) @(posedge clk);
        bad_count++;
        complete_run;
    end

    // Main sequence
    initial begin
        void'($urandom(32'hbaed656a));
        repeat (4) @(posedge clk);
        rstn <= 1'b1;
        #1;
        chk(dac, 10'h200);
        chk({dac_on, mk_oe, mk}, 3'h0);
        wr_reg(2'h3, 16'h0007);
        rd_reg(2'h1, rv);
        chk(rv, 16'h0);
        rd_reg(2'h2, rv);
        chk(rv, 16'h0);
        // Self-timed scans over every multiplier in clock periods, and multiplier 5 in output cycles
        for (int i = 0; i < 6; i++) begin
            m = (i == 5) ? 2'h1 : i[1:0];
            u = (i != 5);
            n = (i == 4) ? 2047 : (i == 5) ? 3 :
                (m == 2'h0) ? 6 + $urandom % 7 : 2 + $urandom % 3;
            k = 2 + $urandom % 2;
            g = hold_gap(n, m, u);
            prog({u, m, n[10:0]}, k[11:0], u ? 24'h100000 : 24'h400000,
                 24'h000800, 3'b000);
            base = mk_cnt;
            pulse_ctrl;
            for (int j = 1; j <= k; j++) begin
                wait_mk(base + j, g + 40);
                if (j > 1) chk(mk_gap, g);
            end
            repeat (2 * g + 10) @(posedge clk);
            chk(mk_cnt, base + k);
        end
        // End-of-scan level; scan length grows by one interval per step
        n = 2 + $urandom % 8;
        for (int kk = 2; kk < 4; kk++) begin
            prog({1'b1, 2'h0, n[10:0]}, kk[11:0], 24'h100000, 24'h1000, 3'b010);
            #1 chk(mk, 1'b0);
            t0 = cyc;
            pulse_ctrl;
            repeat (40) @(posedge clk);
            #1 chk(mk, 1'b1);
            tt[kk - 2] = mk_last - t0;
        end
        chk(tt[1] - tt[0], n);
        // Pin-paced steps, rising and falling frequency
        for (int dir = 0; dir < 2; dir++) begin
            prog({1'b1, 2'h0, 11'h2}, 12'h2, dir ? 24'h200000 : 24'h100000,
                 {dir[0], 23'h100000}, {2'b10, dir[0]});
            base = mk_cnt;
            pulse_ctrl;
            sq_period(dir ? 8 : 16);
            wave_sum(dir ? 8 : 16, dir ? 4096 : 8184);
            for (int j = 1; j < 4; j++) begin
                pulse_ctrl;
                chk(mk_cnt - base, (j < 3) ? j : 2);
                if (j == 1) sq_period(dir ? 16 : 8);
            end
        end
        // Standby freeze, then abort back to midscale
        prog({1'b1, 2'h0, 11'h7ff}, 12'h2, 24'h100000, 24'h0, 3'b000);
        pulse_ctrl;
        wave_sum(16, 8184);
        pins(3'h4);
        d0 = dac;
        repeat (10) @(posedge clk);
        chk(dac, d0);
        pins(3'h0);
        pins(3'h2);
        repeat (4) @(posedge clk);
        #1 chk(dac, 10'h200);
        pins(3'h0);
        // Marker disabled, analog enable kept
        wr_reg(2'h0, 16'h0403);
        repeat (2) @(posedge clk);
        #1 chk({dac_on, mk_oe, mk}, 3'h4);
        complete_run;
    end
endmodule
`default_nettype wire
